//--- voltage_measurement_sequencer.sv
/*
  Voltage measurement sequencer: steps a 14-bit converter through a fixed
  slot order, flags cycle completion and copies results on host command.
  Assumes host controls arrive as synchronous one-cycle write strobes and
  that the converter returns at most one result per slot.
*/
`timescale 1ns/100ps
`default_nettype none

module voltage_measurement_sequencer
  import voltage_sequencer_pkg::*;
#(
  parameter int CELL_COUNT = DEFAULT_CELL_COUNT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Power mode and run configuration
  input wire logic activeMode,
  input wire logic continuousRunBit,
  // Host write strobes
  input wire logic triggerWrite,
  input wire logic captureWrite,
  input wire logic doneClearWrite,
  // Converter
  output adc_request_type adcRequest,
  input wire logic adcValid,
  input wire logic [RESULT_BITS-1:0] adcResult,
  // Result read port
  input wire logic [4:0] resultIndex,
  output logic [RESULT_BITS-1:0] resultData,
  // Status
  output seq_status_type status,
  output logic cycleBusy
);

  // Converted channels: twelve fixed ones plus the cells.
  localparam int CHANNELS = 12 + CELL_COUNT;
  localparam logic [4:0] LAST_SLOT = 5'(CHANNELS);

  initial begin
    if (CELL_COUNT < 1 || CELL_COUNT > DEFAULT_CELL_COUNT) begin
      $error("CELL_COUNT must lie between 1 and 17");
    end
    if (CELL_COUNT == DEFAULT_CELL_COUNT && CHANNELS + 1 != CYCLE_SLOTS) begin
      $error("slot plan does not match the cycle length");
    end
  end

  typedef struct packed {
    mode_type mode;
    logic [4:0] slot;
    logic [8:0] tick;
    logic trigger;
    logic done;
    logic indication;
    logic captureBusy;
    adc_request_type adcReq;
    logic [CHANNELS-1:0][RESULT_BITS-1:0] work;
    logic [CHANNELS-1:0][RESULT_BITS-1:0] capt;
    logic [RESULT_BITS-1:0] readData;
  } regs_type;

  regs_type r;
  regs_type next_r;

  // Request for the conversion held in a given slot.
  function automatic adc_request_type slotRequest(input logic [4:0] slot);
    adc_request_type req;
    req.start = 1'b1;
    req.channel = slot;
    req.posTerminal = 5'h00;
    req.negTerminal = 5'h00;
    if (slot >= FIRST_CELL_SLOT) begin
      req.posTerminal = 5'(slot - FIRST_CELL_SLOT + 5'h01);
      req.negTerminal = 5'(slot - FIRST_CELL_SLOT);
    end
    return req;
  endfunction

  always_comb begin
    next_r = r;
    next_r.adcReq.start = 1'b0;

    // Clearing comes first so a same-cycle cycle end can set it again.
    if (doneClearWrite) begin
      next_r.done = 1'b0;
    end

    // The copy takes one cycle after the command is taken.
    if (r.captureBusy) begin
      next_r.capt = r.work;
      next_r.captureBusy = 1'b0;
      next_r.indication = 1'b0;
    end else if (captureWrite) begin
      next_r.captureBusy = 1'b1;
    end

    unique case (r.mode)
      IDLE: begin
        if (activeMode && (continuousRunBit || r.trigger)) begin
          next_r.mode = RUN;
          next_r.slot = RESET_SLOT;
          next_r.tick = 9'h000;
        end
      end
      RUN: begin
        if (!activeMode) begin
          // An aborted cycle neither flags completion nor consumes the trigger.
          next_r.mode = IDLE;
          next_r.slot = RESET_SLOT;
          next_r.tick = 9'h000;
        end else begin
          if (adcValid && r.slot != RESET_SLOT) begin
            next_r.work[5'(r.slot - 5'h01)] = adcResult;
          end
          if (r.tick == SLOT_LAST_TICK) begin
            next_r.tick = 9'h000;
            if (r.slot == LAST_SLOT) begin
              next_r.done = 1'b1;
              next_r.indication = 1'b1;
              next_r.trigger = 1'b0;
              next_r.slot = RESET_SLOT;
              if (!continuousRunBit) begin
                next_r.mode = IDLE;
              end
            end else begin
              next_r.slot = 5'(r.slot + 5'h01);
              next_r.adcReq = slotRequest(5'(r.slot + 5'h01));
            end
          end else begin
            next_r.tick = 9'(r.tick + 9'h001);
          end
        end
      end
    endcase

    // A new trigger write wins over the end-of-cycle clear.
    if (triggerWrite && !continuousRunBit) begin
      next_r.trigger = 1'b1;
    end

    // Results change only on a capture, never as cycles run.
    if (resultIndex < LAST_SLOT) begin
      next_r.readData = r.capt[resultIndex];
    end else begin
      next_r.readData = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign adcRequest = r.adcReq;
  assign resultData = r.readData;
  assign status.singleCycleTrigger = r.trigger;
  assign status.conversionDoneFlag = r.done;
  assign status.resultCaptureCommand = r.captureBusy;
  assign status.cycleDoneIndication = r.indication;
  assign cycleBusy = (r.mode == RUN);

endmodule

`default_nettype wire

//--- voltage_sequencer_pkg.sv
/*
  Shared constants and carrier types for the voltage measurement sequencer.
  Assumes a single 10 MHz core clock and a converter that answers each
  conversion request with one result strobe inside the same slot.
*/
`default_nettype none

package voltage_sequencer_pkg;

  // Converter resolution in bits.
  localparam int RESULT_BITS = 14;

  // Clock period and slot timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLOT_TIME_NS = 50000;
  localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SLOT_LAST_TICK = 9'(SLOT_CYCLES - 1);

  // Documented slot count per cycle, reset slot included.
  localparam int CYCLE_SLOTS = 30;
  localparam int DEFAULT_CELL_COUNT = 17;

  // Slot codes in conversion order; slot zero is the reset period.
  localparam logic [4:0] RESET_SLOT = 5'h00;
  localparam logic [4:0] SECOND_REFERENCE_CHANNEL = 5'h01;
  localparam logic [4:0] CORE_SUPPLY_CHANNEL = 5'h02;
  localparam logic [4:0] EXTERNAL_REGULATOR_CHANNEL = 5'h03;
  localparam logic [4:0] GPIO1_INPUT_CHANNEL = 5'h04;
  localparam logic [4:0] GPIO2_INPUT_CHANNEL = 5'h05;
  localparam logic [4:0] PACK_VOLTAGE_CHANNEL = 5'h06;
  localparam logic [4:0] THERMISTOR_CHANNELS = 5'h07;
  localparam logic [4:0] MID_SUPPLY_CHANNEL = 5'h0C;
  localparam logic [4:0] FIRST_CELL_SLOT = 5'h0D;

  // Sequencer modes.
  typedef enum logic [0:0] {
    IDLE = 1'b0,
    RUN = 1'b1
  } mode_type;

  // One conversion request towards the analog front end.
  typedef struct packed {
    logic start;
    logic [4:0] channel;
    logic [4:0] posTerminal;
    logic [4:0] negTerminal;
  } adc_request_type;

  // Host-visible status bits.
  typedef struct packed {
    logic singleCycleTrigger;
    logic conversionDoneFlag;
    logic resultCaptureCommand;
    logic cycleDoneIndication;
  } seq_status_type;

endpackage

`default_nettype wire

//--- voltage_sequencer_properties.sv
/* Port checker for the sequencer, bound to its top module.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module voltage_sequencer_properties
  import voltage_sequencer_pkg::*;
(
  // Watched ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic activeMode,
  input wire logic captureWrite,
  input wire logic doneClearWrite,
  input wire adc_request_type adcRequest,
  input wire seq_status_type status,
  input wire logic cycleBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence capt_seq;
    status.resultCaptureCommand ##1 !status.resultCaptureCommand;
  endsequence
  capt_pulse_a:
    assert property (captureWrite && !status.resultCaptureCommand |=> capt_seq)
      else $error("capture");
  ind_drop_a:
    assert property ($fell(status.resultCaptureCommand) |-> !status.cycleDoneIndication)
      else $error("indication");
  done_set_a:
    assert property ($fell(cycleBusy) && activeMode |-> status.conversionDoneFlag
      && status.cycleDoneIndication) else $error("done");
  done_hold_a:
    assert property (status.conversionDoneFlag && !doneClearWrite |=> status.conversionDoneFlag)
      else $error("hold");
  done_clear_a:
    assert property (doneClearWrite && !cycleBusy |=> !status.conversionDoneFlag)
      else $error("clear");
  idle_stop_a:
    assert property (!activeMode [*2] |-> !cycleBusy) else $error("inactive");
  cell_terms_a:
    assert property (adcRequest.start && adcRequest.channel >= FIRST_CELL_SLOT |->
      adcRequest.negTerminal == adcRequest.channel - FIRST_CELL_SLOT
      && adcRequest.posTerminal == adcRequest.negTerminal + 5'h01) else $error("terms");
  slot_order_a:
    assert property (adcRequest.start && adcRequest.channel != SECOND_REFERENCE_CHANNEL
      |-> adcRequest.channel == $past(adcRequest.channel) + 5'h01) else $error("order");
endmodule
bind voltage_measurement_sequencer voltage_sequencer_properties i_props (.core_clk, .rst_n,
  .activeMode, .captureWrite, .doneClearWrite, .adcRequest, .status, .cycleBusy);
`default_nettype wire

//--- adc_model.sv
/* Converter model: one result strobe per request, prompt or one cycle late.
   Assumes start pulses at least two cycles apart. */
`timescale 1ns/100ps
`default_nettype none
module adc_model
  import voltage_sequencer_pkg::*;
(
  // Request side
  input wire logic core_clk,
  input wire adc_request_type adcRequest,
  // Answer shape
  input wire logic slow,
  input wire logic [RESULT_BITS-1:0] salt,
  // Result side
  output logic adcValid,
  output logic [RESULT_BITS-1:0] adcResult
);
  logic late;
  wire logic fire = slow ? late : adcRequest.start;
  // Between strobes the bus flips, so a stale code is never mistaken for data.
  always @(posedge core_clk) begin
    late <= adcRequest.start;
    adcValid <= fire;
    adcResult <= fire ? salt ^ RESULT_BITS'(adcRequest.channel) : ~adcResult;
  end
endmodule
`default_nettype wire

//--- voltage_measurement_sequencer_tb.sv
/* Self-checking bench: single, capture, hold and continuous runs.
   Assumes the converter model of adc_model.sv. */
`timescale 1ns/100ps
`default_nettype none
module voltage_measurement_sequencer_tb;
  import voltage_sequencer_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic activeMode = 1'b1;
  logic continuousRunBit = 1'b0;
  logic triggerWrite = 1'b0;
  logic captureWrite = 1'b0;
  logic doneClearWrite = 1'b0;
  logic slow = 1'b0;
  logic [RESULT_BITS-1:0] salt = 14'h1A5C;
  logic [4:0] resultIndex = 5'h00;
  adc_request_type adcRequest;
  logic adcValid;
  logic [RESULT_BITS-1:0] adcResult;
  logic [RESULT_BITS-1:0] resultData;
  seq_status_type status;
  logic cycleBusy;
  int fails = 0;
  int samplesChecked = 0;
  voltage_measurement_sequencer i_dut (.core_clk, .rst_n, .activeMode, .continuousRunBit,
    .triggerWrite, .captureWrite, .doneClearWrite, .adcRequest, .adcValid, .adcResult,
    .resultIndex, .resultData, .status, .cycleBusy);
  adc_model i_adc (.core_clk, .adcRequest, .slow, .salt, .adcValid, .adcResult);
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samplesChecked++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk) s = 1'b0;
  endtask
  task automatic t_single;
    int n;
    pulse(triggerWrite);
    for (n = 1; (n < 3 || status.singleCycleTrigger === 1'b1) && n < 16000; n++) begin
      @(negedge core_clk);
    end
    // The trigger falls a full cycle of slots after the start edge, which is one edge after the write.
    check(16'(n), 16'(CYCLE_SLOTS * SLOT_CYCLES + 2));
    check(16'({status, cycleBusy}), 16'h000A);
    $display("single cycle done");
  endtask
  task automatic t_capture;
    check(16'(status.conversionDoneFlag), 16'h0001);
    pulse(captureWrite);
    check(16'(status.resultCaptureCommand), 16'h0001);
    @(negedge core_clk);
    check(16'({status.resultCaptureCommand, status.cycleDoneIndication}), 16'h0000);
    for (int i = 0; i < 29; i++) begin
      resultIndex = 5'(i);
      @(negedge core_clk);
      check(16'(resultData), 16'(salt ^ 14'(i + 1)));
    end
    pulse(doneClearWrite);
    @(negedge core_clk);
    check(16'(status.conversionDoneFlag), 16'h0000);
    $display("capture done");
  endtask
  task automatic t_hold;
    logic [RESULT_BITS-1:0] old;
    old = salt;
    salt = 14'h2C3D;
    slow = 1'b1;
    t_single;
    resultIndex = 5'h1C;
    @(negedge core_clk);
    check(16'(resultData), 16'(old ^ 14'h001D));
    t_capture;
    $display("hold done");
  endtask
  task automatic t_cont;
    continuousRunBit = 1'b1;
    for (int n = 0; status.cycleDoneIndication !== 1'b1 && n < 16000; n++) begin
      @(negedge core_clk);
    end
    check(16'({cycleBusy, status.singleCycleTrigger}), 16'h0002);
    activeMode = 1'b0;
    pulse(doneClearWrite);
    repeat (600) @(negedge core_clk);
    check(16'({cycleBusy, status.conversionDoneFlag}), 16'h0000);
    $display("continuous done");
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_single;
    t_capture;
    t_hold;
    t_cont;
    end_of_test;
  end
  initial begin
    repeat (70000) @(posedge core_clk);
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
